//--- hw/wdl_supervision_timer.sv
// Supervision timer with password access, init_done_lock line and reset prewarning
`timescale 1ns/10ps
module wdl_supervision_timer #(
    parameter int PREWARN_CYCLES = wdl_pkg::PREWARN_CYCLES_DEF,
    parameter int WINDOW_CYCLES = wdl_pkg::WINDOW_CYCLES_DEF
) (
    // Clock and resets
    input wire logic clk,
    input wire logic srst,
    input wire logic por_rst,
    // Avalon-MM slave
    input wire logic [4:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // System lines
    output logic init_done_lock,
    output logic nmi,
    output logic sys_reset_req,
    output logic reset_hold,
    // Interrupt
    output logic irq
);
    localparam int IRQ_W_L = wdl_pkg::IRQ_W;
    localparam logic [15:0] WINDOW_LOAD = 16'(WINDOW_CYCLES - 1);
    localparam logic [15:0] PREWARN_LOAD = 16'(PREWARN_CYCLES - 1);

    // Reset and bus handshake
    logic rst_all;
    logic ack_reg;
    logic wr_go;
    logic [31:0] readdata_reg;
    logic [31:0] rd_next;

    // Two-write access sequence
    wdl_pkg::wdl_ctrl_t wctrl;
    logic ctrl_wr;
    logic pw_ok;
    logic guard_ok;
    logic first_ok;
    logic first_bad;
    logic second_ok;
    logic second_bad;
    logic window_exp;
    logic acc_err;
    logic unlocked_reg;
    logic [15:0] window_reg;

    // Stored control word and configuration
    logic init_done_reg;
    logic [5:0] pw_reg;
    logic [15:0] reload_reg;
    logic dis_reg;
    logic slow_reg;

    // Counter and mode sequence
    logic tick;
    logic cnt_run;
    logic ovf;
    logic [15:0] cnt_reg;
    wdl_pkg::wdl_state_t state_reg;
    logic [15:0] delay_reg;
    logic err_take;
    logic enter_reset;

    // Double reset memory
    logic seen_reg;
    logic hold_reg;

    // Interrupt status and mask
    logic [IRQ_W_L-1:0] irq_stat_reg;
    logic [IRQ_W_L-1:0] irq_mask_reg;
    logic [IRQ_W_L-1:0] irq_set;
    logic [IRQ_W_L-1:0] irq_clr;

    // System reset clears all but the double reset memory
    assign rst_all = srst | por_rst;

    // Bus handshake: every access answers on its second cycle
    assign waitrequest = (read | write) & ~ack_reg;
    assign wr_go = write & ack_reg;

    // Wait state flop, dropped once the answer has been given
    always_ff @(posedge clk) begin
        if (rst_all) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= (read | write) & ~ack_reg;
        end
    end

    // Access sequence decode
    assign wctrl = wdl_pkg::wdl_ctrl_t'(writedata);
    assign ctrl_wr = wr_go && (address == wdl_pkg::ADDR_CTRL);
    assign pw_ok = (wctrl.key == wdl_pkg::PW_FIXED) && (wctrl.pw == pw_reg); // R9
    assign guard_ok = (wctrl.key == wdl_pkg::GUARD_FIXED);
    assign first_ok = ctrl_wr & ~unlocked_reg & pw_ok; // R8
    assign first_bad = ctrl_wr & ~unlocked_reg & ~pw_ok; // R11
    assign second_ok = ctrl_wr & unlocked_reg & guard_ok; // R8
    assign second_bad = ctrl_wr & unlocked_reg & ~guard_ok; // R11
    assign window_exp = unlocked_reg & ~ctrl_wr & (window_reg == 16'h0000); // R10
    assign acc_err = first_bad | second_bad | window_exp;

    // Unlock window between the two writes
    // Writes to other registers leave the window running
    always_ff @(posedge clk) begin
        if (rst_all) begin
            unlocked_reg <= 1'b0;
            window_reg <= 16'h0000;
        end else if (first_ok) begin
            unlocked_reg <= 1'b1;
            window_reg <= WINDOW_LOAD; // R10 R16
        end else if (ctrl_wr | window_exp) begin
            unlocked_reg <= 1'b0; // R10
        end else if (unlocked_reg) begin
            window_reg <= window_reg - 16'h0001;
        end
    end

    // Control word, changed only by a complete sequence
    // The pw field of the second write becomes the next password
    always_ff @(posedge clk) begin
        if (rst_all) begin
            init_done_reg <= 1'b0;
            pw_reg <= wdl_pkg::PW_RESET;
            reload_reg <= wdl_pkg::RELOAD_RESET;
        end else if (second_ok) begin
            init_done_reg <= wctrl.init_done; // R6 R8
            pw_reg <= wctrl.pw;
            reload_reg <= wctrl.reload;
        end
    end

    // Protection line follows the stored bit directly
    assign init_done_lock = init_done_reg; // R5

    // Configuration, writable only while the protection line is low
    always_ff @(posedge clk) begin
        if (rst_all) begin
            dis_reg <= 1'b0;
            slow_reg <= 1'b0;
        end else if (wr_go && (address == wdl_pkg::ADDR_CFG) && !init_done_reg) begin
            dis_reg <= writedata[wdl_pkg::CFG_DIS_BIT];
            slow_reg <= writedata[wdl_pkg::CFG_SLOW_BIT]; // R3
        end
    end

    // Count clock source
    wdl_prescaler u_prescaler (
        .clk(clk),
        .srst(rst_all),
        .slow_sel(slow_reg),
        .tick(tick)
    );

    // Disable stops only normal mode; timeout mode always counts
    assign cnt_run = ((state_reg == wdl_pkg::ST_NORMAL) & ~dis_reg) | (state_reg == wdl_pkg::ST_TIMEOUT); // R13
    assign ovf = cnt_run & tick & (cnt_reg == wdl_pkg::CNT_LAST); // R12 R1
    // Errors count only while a prewarn can still be started
    assign err_take = (acc_err | ovf) &&
        ((state_reg == wdl_pkg::ST_NORMAL) || (state_reg == wdl_pkg::ST_TIMEOUT));

    // Upward counter with reload on service and on prewarn entry
    always_ff @(posedge clk) begin
        if (rst_all) begin
            cnt_reg <= wdl_pkg::FIXED_RELOAD;
        end else if (err_take) begin
            cnt_reg <= wdl_pkg::FIXED_RELOAD; // R4
        end else if (second_ok && (state_reg != wdl_pkg::ST_PREWARN) && (state_reg != wdl_pkg::ST_RESET)) begin
            if (wctrl.init_done) begin
                cnt_reg <= wctrl.reload; // R4 R15
            end else begin
                cnt_reg <= wdl_pkg::FIXED_RELOAD; // R4 R15
            end
        end else if (cnt_run & tick) begin
            cnt_reg <= cnt_reg + 16'h0001; // R3 R15
        end
    end

    // Mode sequence: errors go to prewarn, prewarn times out into reset
    assign enter_reset = (state_reg == wdl_pkg::ST_PREWARN) && (delay_reg == 16'h0000);

    // Errors in prewarn or reset change nothing, the outcome is already fixed
    always_ff @(posedge clk) begin
        if (rst_all) begin
            state_reg <= wdl_pkg::ST_TIMEOUT;
            delay_reg <= 16'h0000;
        end else begin
            case (state_reg)
                wdl_pkg::ST_TIMEOUT, wdl_pkg::ST_NORMAL: begin
                    if (err_take) begin
                        state_reg <= wdl_pkg::ST_PREWARN; // R7 R11 R12
                        delay_reg <= PREWARN_LOAD; // R16
                    end else if (init_done_reg) begin
                        state_reg <= wdl_pkg::ST_NORMAL;
                    end else begin
                        state_reg <= wdl_pkg::ST_TIMEOUT;
                    end
                end
                wdl_pkg::ST_PREWARN: begin
                    if (enter_reset) begin
                        state_reg <= wdl_pkg::ST_RESET; // R7 R1
                    end else begin
                        delay_reg <= delay_reg - 16'h0001;
                    end
                end
                wdl_pkg::ST_RESET: begin
                    // Left only through srst from the reset controller or through por_rst
                    state_reg <= wdl_pkg::ST_RESET;
                end
                default: begin
                    state_reg <= wdl_pkg::ST_TIMEOUT;
                end
            endcase
        end
    end

    // Double reset memory survives srst; hold cleared only by power-on, seen also by a completed sequence
    // Hazard: the srst pulse from the reset controller must not wipe it
    always_ff @(posedge clk) begin
        if (por_rst) begin
            seen_reg <= 1'b0;
            hold_reg <= 1'b0;
        end else if (enter_reset) begin
            seen_reg <= 1'b1;
            if (seen_reg) begin
                hold_reg <= 1'b1; // R14
            end
        end else if (second_ok) begin
            seen_reg <= 1'b0; // R14
        end
    end

    // System lines decoded from state flops
    assign nmi = (state_reg == wdl_pkg::ST_PREWARN); // R7
    assign sys_reset_req = (state_reg == wdl_pkg::ST_RESET) | hold_reg; // R1 R14
    assign reset_hold = hold_reg;

    // Sticky events; a set in the clearing cycle wins
    always_comb begin
        irq_set = '0;
        irq_set[wdl_pkg::IRQ_ACC_BIT] = acc_err;
        irq_set[wdl_pkg::IRQ_OVF_BIT] = ovf;
        irq_set[wdl_pkg::IRQ_SVC_BIT] = second_ok;
    end

    // Write-one-to-clear strobes for the status bits
    assign irq_clr = (wr_go && (address == wdl_pkg::ADDR_IRQ_STAT)) ? writedata[IRQ_W_L-1:0] : '0;

    // Status bits hold until software clears them
    always_ff @(posedge clk) begin
        if (rst_all) begin
            irq_stat_reg <= '0;
        end else begin
            irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
        end
    end

    // Mask register, same layout as the status register
    always_ff @(posedge clk) begin
        if (rst_all) begin
            irq_mask_reg <= '0;
        end else if (wr_go && (address == wdl_pkg::ADDR_IRQ_MASK)) begin
            irq_mask_reg <= writedata[IRQ_W_L-1:0];
        end
    end

    // Level interrupt while any unmasked event is pending
    assign irq = |(irq_stat_reg & irq_mask_reg);

    // Read mux; unmapped offsets read as zero
    always_comb begin
        rd_next = 32'h00000000;
        if (address == wdl_pkg::ADDR_CTRL) begin
            rd_next = {reload_reg, 8'h00, pw_reg, unlocked_reg, init_done_reg};
        end else if (address == wdl_pkg::ADDR_CFG) begin
            rd_next[wdl_pkg::CFG_DIS_BIT] = dis_reg;
            rd_next[wdl_pkg::CFG_SLOW_BIT] = slow_reg;
        end else if (address == wdl_pkg::ADDR_STAT) begin
            rd_next[wdl_pkg::STAT_STATE_LSB +: 2] = state_reg;
            rd_next[wdl_pkg::STAT_NMI_BIT] = nmi;
            rd_next[wdl_pkg::STAT_SEEN_BIT] = seen_reg;
            rd_next[wdl_pkg::STAT_HOLD_BIT] = hold_reg;
            rd_next[wdl_pkg::STAT_CNT_LSB +: 16] = cnt_reg;
        end else if (address == wdl_pkg::ADDR_IRQ_STAT) begin
            rd_next[IRQ_W_L-1:0] = irq_stat_reg;
        end else if (address == wdl_pkg::ADDR_IRQ_MASK) begin
            rd_next[IRQ_W_L-1:0] = irq_mask_reg;
        end
    end

    // Read data captured in the waiting cycle so it stands when waitrequest drops
    always_ff @(posedge clk) begin
        if (rst_all) begin
            readdata_reg <= 32'h00000000;
        end else if (read & ~ack_reg) begin
            readdata_reg <= rd_next;
        end
    end

    // Bus read data comes straight from a flop
    assign readdata = readdata_reg;
endmodule

//--- hw/wdl_pkg.sv
// Constants, field layouts and types for the supervision timer block
// What this block does
// R1: While supervision is on, a missing service access before the count overflows leads to a system reset request.
// R2: Software must complete a valid service sequence inside every timeout interval.
// R3: A 16-bit counter advances on the system clock divided by 256 or by 16384, chosen by a setting.
// R4: Normal mode reloads the counter from the 16-bit user value; timeout and prewarning modes reload a fixed value.
// R5: The init_done_lock bit is held here and driven out on a system-wide write-protection line.
// R6: The init_done_lock bit can only be changed through the supervised two-write sequence.
// R7: An error first raises the non-maskable interrupt and only after a set delay the system reset.
// R8: A control change takes effect only after two successive writes to the control register.
// R9: The first write is checked against a password of fixed and user-definable fields.
// R10: The gap between first and second write is timed and limited.
// R11: A wrong password on the first write or wrong guard bits on the second start reset generation.
// R12: A counter overflow starts reset generation.
// R13: Supervision can be switched off while password protection and init_done_lock monitoring stay active.
// R14: A second watchdog reset without a proper access in between holds the system in reset until power-on reset.
// R15: A completed service sequence reloads the upward counter from the active reload value.
// R16: The prewarning delay and the allowed write gap are parameters.
package wdl_pkg;
    // Register byte offsets
    localparam logic [4:0] ADDR_CTRL = 5'h00;
    localparam logic [4:0] ADDR_CFG = 5'h04;
    localparam logic [4:0] ADDR_STAT = 5'h08;
    localparam logic [4:0] ADDR_IRQ_STAT = 5'h0C;
    localparam logic [4:0] ADDR_IRQ_MASK = 5'h10;

    // Configuration bit positions
    localparam int CFG_DIS_BIT = 0;
    localparam int CFG_SLOW_BIT = 1;

    // Status register bit positions
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_NMI_BIT = 2;
    localparam int STAT_SEEN_BIT = 3;
    localparam int STAT_HOLD_BIT = 4;
    localparam int STAT_CNT_LSB = 16;

    // Interrupt status and mask bit positions
    localparam int IRQ_W = 3;
    localparam int IRQ_ACC_BIT = 0;
    localparam int IRQ_OVF_BIT = 1;
    localparam int IRQ_SVC_BIT = 2;

    // Password and guard patterns, reset values
    localparam logic [7:0] PW_FIXED = 8'hA5;
    localparam logic [7:0] GUARD_FIXED = 8'h5A;
    localparam logic [5:0] PW_RESET = 6'h00;
    localparam logic [15:0] RELOAD_RESET = 16'h0000;
    localparam logic [15:0] FIXED_RELOAD = 16'hFFFC;
    localparam logic [15:0] CNT_LAST = 16'hFFFF;

    // Prescaler terminal counts for divide by 256 and by 16384
    localparam logic [7:0] FAST_LAST = 8'hFF;
    localparam logic [13:0] SLOW_LAST = 14'h3FFF;

    // Timing counts in system clock cycles
    localparam int PREWARN_CYCLES_DEF = 8192;
    localparam int WINDOW_CYCLES_DEF = 64;

    // Operating modes, Gray coded along timeout, normal, prewarn, reset
    typedef enum logic [1:0] {
        ST_TIMEOUT = 2'b00,
        ST_NORMAL = 2'b01,
        ST_PREWARN = 2'b11,
        ST_RESET = 2'b10
    } wdl_state_t;

    // Layout of a control register write
    typedef struct packed {
        logic [15:0] reload;
        logic [7:0] key;
        logic [5:0] pw;
        logic unlocked;
        logic init_done;
    } wdl_ctrl_t;
endpackage

//--- hw/wdl_prescaler.sv
// Count clock prescaler for the supervision timer
`timescale 1ns/10ps
module wdl_prescaler (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Divider choice, high selects the slow rate
    input wire logic slow_sel,
    // One-cycle count enable
    output logic tick
);
    logic [13:0] cnt_reg;
    logic tick_reg;

    // Free running divider; both rates share one counter to save flops
    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_reg <= 14'h0000;
            tick_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_reg + 14'h0001;
            if (slow_sel) begin
                tick_reg <= (cnt_reg == wdl_pkg::SLOW_LAST); // R3
            end else begin
                tick_reg <= (cnt_reg[7:0] == wdl_pkg::FAST_LAST); // R3
            end
        end
    end

    assign tick = tick_reg;
endmodule

//--- verification/wdl_assertions.sv
// Port level checks for the supervision timer
`timescale 1ns/10ps
module wdl_assertions #(
    parameter int PREWARN_CYCLES = wdl_pkg::PREWARN_CYCLES_DEF,
    parameter int WINDOW_CYCLES = wdl_pkg::WINDOW_CYCLES_DEF
) (
    // Clock and resets
    input wire logic clk,
    input wire logic srst,
    input wire logic por_rst,
    // Register bus
    input wire logic [4:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic waitrequest,
    // System lines
    input wire logic init_done_lock,
    input wire logic nmi,
    input wire logic sys_reset_req,
    input wire logic reset_hold
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst || por_rst);
    // Bus slave answers after exactly one wait cycle
    a_wait_one: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("bus request not answered after one wait cycle");
    a_idle_nowait: assert property (!read && !write |-> !waitrequest)
        else $error("waitrequest high with no request");
    // Protection line moves only on an accepted control write
    a_lock_by_write: assert property ($changed(init_done_lock) |->
        $past(write) && !$past(waitrequest) && $past(address) == wdl_pkg::ADDR_CTRL)
        else $error("init_done_lock changed without a control write");
    // Prewarning stands for a while before the reset request
    a_nmi_holds: assert property ($rose(nmi) |-> nmi [*8])
        else $error("nmi dropped too early");
    a_reset_follows: assert property ($rose(nmi) |-> ##[8:40] sys_reset_req)
        else $error("no reset request after prewarning");
    a_nmi_first: assert property ($rose(sys_reset_req) |-> $past(nmi))
        else $error("reset request without prewarning");
    a_nmi_ends: assert property ($fell(nmi) |-> sys_reset_req)
        else $error("nmi ended without reset request");
    // Reset state is left only through a system reset
    a_reset_stays: assert property (sys_reset_req |=> sys_reset_req)
        else $error("reset request dropped without reset");
    // Reset hold survives system resets, only power-on clears it
    a_hold_sticky: assert property (@(posedge clk) disable iff (por_rst) reset_hold |=> reset_hold)
        else $error("reset hold cleared without power-on reset");
    a_hold_asserts: assert property (@(posedge clk) disable iff (por_rst) reset_hold |-> sys_reset_req)
        else $error("reset hold without reset request");
    c_prewarn: cover property ($rose(nmi));
    c_hold: cover property (@(posedge clk) disable iff (por_rst) $rose(reset_hold));
    c_lock: cover property ($rose(init_done_lock));
endmodule
bind wdl_supervision_timer wdl_assertions #(.PREWARN_CYCLES(PREWARN_CYCLES), .WINDOW_CYCLES(WINDOW_CYCLES))
    u_wdl_assertions (.clk(clk), .srst(srst), .por_rst(por_rst), .address(address), .read(read), .write(write),
    .waitrequest(waitrequest), .init_done_lock(init_done_lock), .nmi(nmi), .sys_reset_req(sys_reset_req),
    .reset_hold(reset_hold));

//--- verification/wdl_rst_ctrl.sv
// Reset controller model that answers reset requests
`timescale 1ns/10ps
module wdl_rst_ctrl (
    // Clock
    input wire logic clk,
    // Request from the timer
    input wire logic sys_reset_req,
    // Reset back into the timer
    output logic rst_out
);
    logic [2:0] cnt_reg = 3'h0;
    // Four cycle pulses, re-armed while a held request stays up
    always_ff @(posedge clk) begin
        if (cnt_reg != 3'h0) begin
            cnt_reg <= cnt_reg - 3'h1;
        end else if (sys_reset_req) begin
            cnt_reg <= 3'h4;
        end
    end
    assign rst_out = cnt_reg != 3'h0;
endmodule

//--- verification/tb.sv
// Self-checking bench for the supervision timer
`timescale 1ns/10ps
module tb;
    logic clk = 1'b0;
    logic srst_tb = 1'b1;
    logic por_rst = 1'b1;
    logic [4:0] address = 5'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata, rd;
    logic waitrequest, init_done_lock, nmi, sys_reset_req, reset_hold, irq, rc_srst, srst;
    int n_mismatch = 0;
    int checks = 0;
    int cyc = 0;
    int n;
    assign srst = srst_tb | rc_srst;
    initial begin
        forever #2.5 clk = ~clk;
    end
    // Short prewarning and window keep the run brief
    wdl_supervision_timer #(.PREWARN_CYCLES(16), .WINDOW_CYCLES(8)) u_wdl_supervision_timer (.clk(clk),
        .srst(srst), .por_rst(por_rst), .address(address), .read(read), .write(write), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest), .init_done_lock(init_done_lock), .nmi(nmi),
        .sys_reset_req(sys_reset_req), .reset_hold(reset_hold), .irq(irq));
    wdl_rst_ctrl u_wdl_rst_ctrl (.clk(clk), .sys_reset_req(sys_reset_req), .rst_out(rc_srst));
    task automatic give_verdict();
        $display("checks=%0d mismatches=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One bus transfer, held until waitrequest is seen low; the idle edge after it lets results settle
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        address <= a;
        write <= wr;
        read <= ~wr;
        writedata <= d;
        do @(posedge clk); while (waitrequest !== 1'b0);
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clk);
    endtask
    function automatic logic [31:0] cw(logic [15:0] rl, logic [7:0] k, logic [5:0] p, logic init);
        wdl_pkg::wdl_ctrl_t c;
        c = '{reload: rl, key: k, pw: p, unlocked: 1'b0, init_done: init};
        return c;
    endfunction
    // Bounded wait for nmi or the reset request to reach a level
    task automatic wait_on(input int sel, input logic v, input int lim);
        n = 0;
        while ((sel == 0 ? nmi : sys_reset_req) !== v && n < lim) begin
            @(posedge clk);
            n++;
        end
    endtask
    task automatic ride_reset();
        wait_on(1, 1'b1, 40);
        wait_on(1, 1'b0, 40);
        repeat (6) @(posedge clk);
    endtask
    task automatic svc(input logic [5:0] p, input logic [5:0] pn, input logic [15:0] rl, input logic init);
        bus(1'b1, wdl_pkg::ADDR_CTRL, cw(16'h0000, wdl_pkg::PW_FIXED, p, 1'b0));
        bus(1'b1, wdl_pkg::ADDR_CTRL, cw(rl, wdl_pkg::GUARD_FIXED, pn, init));
    endtask
    task automatic t_reset();
        bus(1'b0, wdl_pkg::ADDR_STAT, 32'h0);
        chk(rd, 32'hFFFC0000);
        bus(1'b0, 5'h14, 32'h0);
        chk(rd, 32'h0);
        chk({init_done_lock, nmi, irq}, 32'h0);
        $display("test reset done");
    endtask
    task automatic t_service();
        bus(1'b1, wdl_pkg::ADDR_CFG, 32'h1);
        bus(1'b1, wdl_pkg::ADDR_IRQ_MASK, 32'h7);
        svc(6'h00, 6'h15, 16'hFFFE, 1'b1);
        chk(init_done_lock, 32'h1);
        chk(irq, 32'h1);
        bus(1'b0, wdl_pkg::ADDR_IRQ_STAT, 32'h0);
        chk(rd, 32'h4);
        bus(1'b0, wdl_pkg::ADDR_STAT, 32'h0);
        chk(rd[4:0], 32'h1);
        bus(1'b1, wdl_pkg::ADDR_IRQ_STAT, 32'h4);
        chk(irq, 32'h0);
        bus(1'b1, wdl_pkg::ADDR_CFG, 32'h0);
        bus(1'b0, wdl_pkg::ADDR_CFG, 32'h0);
        chk(rd, 32'h1);
        repeat (1500) @(posedge clk);
        chk(nmi, 32'h0);
        $display("test service done");
    endtask
    task automatic t_bad_pw();
        bus(1'b1, wdl_pkg::ADDR_CTRL, cw(16'h0000, wdl_pkg::PW_FIXED, 6'h00, 1'b0));
        wait_on(0, 1'b1, 4);
        chk(nmi, 32'h1);
        bus(1'b0, wdl_pkg::ADDR_IRQ_STAT, 32'h0);
        chk(rd, 32'h1);
        chk(sys_reset_req, 32'h0);
        ride_reset();
        bus(1'b0, wdl_pkg::ADDR_STAT, 32'h0);
        chk({init_done_lock, rd[4:0]}, 32'h8);
        $display("test bad password done");
    endtask
    task automatic t_guard();
        svc(6'h00, 6'h00, 16'h0000, 1'b0);
        bus(1'b0, wdl_pkg::ADDR_STAT, 32'h0);
        chk(rd[4:0], 32'h0);
        bus(1'b1, wdl_pkg::ADDR_CTRL, cw(16'h0000, wdl_pkg::PW_FIXED, 6'h00, 1'b0));
        bus(1'b1, wdl_pkg::ADDR_CTRL, cw(16'h0000, 8'h00, 6'h00, 1'b0));
        wait_on(0, 1'b1, 4);
        chk(nmi, 32'h1);
        ride_reset();
        chk(reset_hold, 32'h0);
        $display("test guard done");
    endtask
    task automatic t_overflow();
        wait_on(0, 1'b1, 1400);
        chk(32'(n >= 900 && n <= 1100), 32'h1);
        wait_on(1, 1'b1, 40);
        repeat (30) @(posedge clk);
        chk({reset_hold, sys_reset_req}, 32'h3);
        por_rst <= 1'b1;
        repeat (2) @(posedge clk);
        por_rst <= 1'b0;
        repeat (8) @(posedge clk);
        chk({reset_hold, sys_reset_req}, 32'h0);
        $display("test overflow done");
    endtask
    task automatic t_window();
        bus(1'b1, wdl_pkg::ADDR_CTRL, cw(16'h0000, wdl_pkg::PW_FIXED, 6'h00, 1'b0));
        wait_on(0, 1'b1, 20);
        chk(32'(n >= 6 && n <= 11), 32'h1);
        ride_reset();
        chk(reset_hold, 32'h0);
        $display("test window done");
    endtask
    // Slow divider: the fast rate would overflow well inside this wait
    task automatic t_slow();
        bus(1'b1, wdl_pkg::ADDR_CFG, 32'h2);
        bus(1'b0, wdl_pkg::ADDR_CFG, 32'h0);
        chk(rd, 32'h2);
        repeat (1200) @(posedge clk);
        bus(1'b0, wdl_pkg::ADDR_STAT, 32'h0);
        chk({nmi, rd[31:16]}, {1'b0, 16'hFFFC});
        $display("test slow divider done");
    endtask
    // Main sequence
    initial begin
        repeat (20) @(posedge clk);
        srst_tb <= 1'b0;
        por_rst <= 1'b0;
        t_reset();
        t_service();
        t_bad_pw();
        t_guard();
        t_overflow();
        t_window();
        t_slow();
        give_verdict();
    end
    // Hang guard, well beyond the expected run
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            give_verdict();
        end
    end
endmodule
